//--- rtl/capture_pkg.sv
package capture_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int SCR_AW = 6;
  localparam int SCR_DEPTH = 64;
  localparam int CTL_W = 4;
  // scratch window in the emulated address space
  localparam logic [ADDR_W-1:0] SCR_BASE = 16'hFF00;
  localparam logic [ADDR_W-1:0] SCR_MASK = 16'hFFC0;
  // location whose fetch signals end of a test program
  localparam logic [SCR_AW-1:0] DONE_LOC = 6'h3_E;
  localparam logic [SCR_AW-1:0] PARK_LOC = 6'h3_F;
  // opcodes: the jump placed in scratch memory by the host side, the forced one driven on a capture fetch
  localparam logic [DATA_W-1:0] OP_JR = 8'h1_8;
  localparam logic [DATA_W-1:0] OP_SELF = 8'hF_E;
  localparam logic [DATA_W-1:0] OP_FORCED = 8'hF_F;
  // capture must finish within this time
  localparam int CAPTURE_TIMEOUT_NS = 20000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAPTURE_TIMEOUT_CYC = CAPTURE_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TMO_W = 12;
  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_WRITE,
    CMD_READ,
    CMD_ACK
  } cmd_e;
endpackage

//--- rtl/capture_if.sv
`timescale 1ns/1ps
interface capture_if;
  import capture_pkg::*;
  logic capture_req;
  logic single_step;
  logic use_nmi;
  logic [CTL_W-1:0] ctl_enable;
  cmd_e cmd;
  logic [SCR_AW-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata;
  logic [DATA_W-1:0] cmd_rdata;
  logic cmd_rvalid;
  logic capture_done_interrupt;
  logic capture_fail;
  logic parked;
  modport dev (
    input capture_req, single_step, use_nmi, ctl_enable, cmd, cmd_addr, cmd_wdata,
    output cmd_rdata, cmd_rvalid, capture_done_interrupt, capture_fail, parked
  );
  modport host (
    output capture_req, single_step, use_nmi, ctl_enable, cmd, cmd_addr, cmd_wdata,
    input cmd_rdata, cmd_rvalid, capture_done_interrupt, capture_fail, parked
  );
endinterface

//--- rtl/personality_controller.sv
`timescale 1ns/1ps
// Overview of operation
// - host raises capture line to request capture
// - capture runs in hardware state machine
// - capture by nmi or forced instruction
// - scratch memory mapped when capture completes
// - done interrupt on fetch of done location
// - processor parks on jump-to-self in scratch
// - host loads programs while processor parked
// - jump to program start, run, signal, park
// - results stay in scratch for host reads
// - host patches park into relative jump
// - sequencer tracks exit toward jump target
// - first user fetch unmaps scratch memory
// - processor state latched during halt capture
// - target control inputs blocked during capture
// - done interrupt when capture completes
// - single step recaptures after first instruction
// - breakpoint captures like halt, then interrupts
// - each target control input individually gated
module personality_controller (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  capture_if.dev HOST,
  input wire logic [capture_pkg::ADDR_W-1:0] CPU_ADDR_I,
  input wire logic CPU_FETCH_I,
  input wire logic CPU_RD_I,
  input wire logic CPU_WR_I,
  input wire logic [capture_pkg::DATA_W-1:0] CPU_WDATA_I,
  input wire logic CPU_NMI_ACK_I,
  input wire logic BREAK_I,
  input wire logic [capture_pkg::CTL_W-1:0] TGT_CTL_I,
  input wire logic [capture_pkg::ADDR_W-1:0] CPU_STATE_I,
  output logic [capture_pkg::DATA_W-1:0] CPU_RDATA_O,
  output logic CPU_RDATA_EN_O,
  output logic CPU_NMI_O,
  output logic SCR_MAPPED_O,
  output logic [capture_pkg::CTL_W-1:0] CPU_CTL_O,
  output logic [capture_pkg::ADDR_W-1:0] SAVED_STATE_O
);
  import capture_pkg::*;

  typedef enum logic [2:0] {
    S_USER,
    S_REQ,
    S_PARK,
    S_EXIT,
    S_STEP
  } seq_e;

  typedef struct packed {
    seq_e st;
    logic mapped;
    logic nmi;
    logic force_op;
    logic irq;
    logic fail;
    logic step;
    logic parked;
    logic [TMO_W-1:0] tmo;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [DATA_W-1:0] cpu_rdata;
    logic cpu_rdata_en;
    logic [CTL_W-1:0] ctl;
    logic [CTL_W-1:0] tctl_m;
    logic [CTL_W-1:0] tctl_s;
    logic [ADDR_W-1:0] saved;
    logic [1:0] brk_s;
  } state_s;

  state_s q, d;
  logic [DATA_W-1:0] mem [SCR_DEPTH];

  function automatic logic in_scr(input logic [ADDR_W-1:0] a);
    in_scr = (a & SCR_MASK) == SCR_BASE;
  endfunction

  logic scr_hit;
  logic done_fetch;
  logic req_now;
  assign scr_hit = in_scr(CPU_ADDR_I);
  assign done_fetch = CPU_FETCH_I && scr_hit && CPU_ADDR_I[SCR_AW-1:0] == DONE_LOC;
  // host line runs on this clock, so of the two request lines only the breakpoint pin is synchronised
  assign req_now = HOST.capture_req || q.brk_s[1];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.brk_s = {q.brk_s[0], BREAK_I};
    // target lines are pins from another domain: two flops before use
    d.tctl_m = TGT_CTL_I;
    d.tctl_s = q.tctl_m;
    d.rvalid = 1'b0;
    // scratch answers one cycle after the access
    d.cpu_rdata = mem[CPU_ADDR_I[SCR_AW-1:0]];
    d.cpu_rdata_en = q.mapped && scr_hit && (CPU_RD_I || CPU_FETCH_I);
    if (HOST.cmd == CMD_READ) begin
      d.rdata = mem[HOST.cmd_addr];
      d.rvalid = 1'b1;
    end
    // ack is applied first so that a set in the same cycle wins
    if (HOST.cmd == CMD_ACK) begin
      d.irq = 1'b0;
    end
    case (q.st)
      S_USER: begin
        d.mapped = 1'b0;
        if (req_now) begin
          d.st = S_REQ;
          d.tmo = '0;
          d.fail = 1'b0;
          d.nmi = HOST.use_nmi;
          d.force_op = ~HOST.use_nmi;
        end
      end
      S_REQ: begin
        d.tmo = q.tmo + 1'b1;
        if (q.force_op && CPU_FETCH_I) begin
          // forced instruction when the cpu type cannot take an nmi, and on every single-step recapture
          d.cpu_rdata = OP_FORCED;
          d.cpu_rdata_en = 1'b1;
        end
        if ((q.nmi && CPU_NMI_ACK_I) || (q.force_op && CPU_FETCH_I)) begin
          d.mapped = 1'b1;
          d.irq = 1'b1;
          d.saved = CPU_STATE_I;
          d.nmi = 1'b0;
          d.force_op = 1'b0;
          d.st = S_PARK;
        end else if (q.tmo == TMO_W'(CAPTURE_TIMEOUT_CYC)) begin
          d.fail = 1'b1;
          d.nmi = 1'b0;
          d.force_op = 1'b0;
          d.st = S_USER;
        end
      end
      S_PARK: begin
        // host patches the park opcode into a jump to start runs
        if (CPU_FETCH_I && scr_hit && CPU_ADDR_I[SCR_AW-1:0] == PARK_LOC
            && mem[PARK_LOC] == OP_JR) begin
          d.st = S_EXIT;
          d.step = HOST.single_step;
        end
      end
      S_EXIT: begin
        if (CPU_FETCH_I && !scr_hit) begin
          d.mapped = 1'b0;
          d.st = q.step ? S_STEP : S_USER;
        end
      end
      S_STEP: begin
        // next fetch ends the first user instruction
        if (CPU_FETCH_I) begin
          d.st = S_REQ;
          d.tmo = '0;
          d.force_op = 1'b1;
        end
      end
      default: d.st = S_USER;
    endcase
    if (done_fetch && q.mapped) begin
      d.irq = 1'b1;
    end
    // all target controls blocked while in scratch
    d.ctl = (q.st == S_USER && !req_now) ? (q.tctl_s & HOST.ctl_enable) : '0;
    d.parked = (d.st == S_PARK);
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '{st: S_USER, default: '0};
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // scratch memory, written by host and by cpu test programs
  // ---------------------------------------------------------------
  // host load wins over a cpu store in the same cycle
  always_ff @(posedge CLK_I) begin
    if (HOST.cmd == CMD_WRITE) begin
      mem[HOST.cmd_addr] <= HOST.cmd_wdata;
    end else if (CPU_WR_I && q.mapped && scr_hit) begin
      mem[CPU_ADDR_I[SCR_AW-1:0]] <= CPU_WDATA_I;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign CPU_RDATA_O = q.cpu_rdata;
  assign CPU_RDATA_EN_O = q.cpu_rdata_en;
  assign CPU_NMI_O = q.nmi;
  assign SCR_MAPPED_O = q.mapped;
  assign CPU_CTL_O = q.ctl;
  assign SAVED_STATE_O = q.saved;
  assign HOST.cmd_rdata = q.rdata;
  assign HOST.cmd_rvalid = q.rvalid;
  assign HOST.capture_done_interrupt = q.irq;
  assign HOST.capture_fail = q.fail;
  assign HOST.parked = q.parked;
endmodule

//--- rtl/host_controller_cpu.sv
`timescale 1ns/1ps
module host_controller_cpu (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  capture_if.host DEV,
  input wire logic CAPTURE_I,
  input wire logic STEP_I,
  input wire logic USE_NMI_I,
  input wire logic [capture_pkg::CTL_W-1:0] CTL_ENABLE_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic ACK_I,
  input wire logic RUN_I,
  input wire logic [capture_pkg::SCR_AW-1:0] ADDR_I,
  input wire logic [capture_pkg::DATA_W-1:0] WDATA_I,
  output logic [capture_pkg::DATA_W-1:0] RDATA_O,
  output logic RVALID_O,
  output logic DONE_O,
  output logic FAIL_O
);
  import capture_pkg::*;

  typedef struct packed {
    logic req;
    logic step;
    logic nmi;
    logic [CTL_W-1:0] en;
    cmd_e cmd;
    logic [SCR_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic done;
    logic fail;
  } state_s;

  state_s q, d;

  // ---------------------------------------------------------------
  // command issue
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.req = CAPTURE_I;
    d.step = STEP_I;
    d.nmi = USE_NMI_I;
    d.en = CTL_ENABLE_I;
    d.cmd = CMD_NONE;
    d.addr = ADDR_I;
    d.wdata = WDATA_I;
    // run patches the park slot with a relative jump
    if (RUN_I && DEV.parked) begin
      d.cmd = CMD_WRITE;
      d.addr = PARK_LOC;
      d.wdata = OP_JR;
    end else if (WR_I && DEV.parked) begin
      d.cmd = CMD_WRITE;
    end else if (RD_I) begin
      d.cmd = CMD_READ;
    end else if (ACK_I) begin
      d.cmd = CMD_ACK;
    end
    d.rdata = DEV.cmd_rdata;
    d.rvalid = DEV.cmd_rvalid;
    d.done = DEV.capture_done_interrupt;
    d.fail = DEV.capture_fail;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '{cmd: CMD_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign DEV.capture_req = q.req;
  assign DEV.single_step = q.step;
  assign DEV.use_nmi = q.nmi;
  assign DEV.ctl_enable = q.en;
  assign DEV.cmd = q.cmd;
  assign DEV.cmd_addr = q.addr;
  assign DEV.cmd_wdata = q.wdata;
  assign RDATA_O = q.rdata;
  assign RVALID_O = q.rvalid;
  assign DONE_O = q.done;
  assign FAIL_O = q.fail;
endmodule

//--- bench/capture_sva.sv
`timescale 1ns/1ps
module capture_sva (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic capture_req,
  input wire capture_pkg::cmd_e cmd,
  input wire logic cmd_rvalid,
  input wire logic capture_done_interrupt,
  input wire logic capture_fail,
  input wire logic parked
);
  import capture_pkg::*;
  // ------
  // checks
  // ------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // a capture must park or fail within this many cycles of the request
  localparam int CAPTURE_LIMIT = 2100;
  logic req_seen_q;
  logic fail_seen_q;
  logic pending_q;
  logic [11:0] wait_cnt_q;
  // too long for a delay range, so the wait is counted here
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      req_seen_q <= 1'b0;
      fail_seen_q <= 1'b0;
      pending_q <= 1'b0;
      wait_cnt_q <= '0;
    end else begin
      req_seen_q <= capture_req;
      fail_seen_q <= capture_fail;
      if (parked || (capture_fail && !fail_seen_q)) begin
        pending_q <= 1'b0;
        wait_cnt_q <= '0;
      end else if (capture_req && !req_seen_q) begin
        pending_q <= 1'b1;
        wait_cnt_q <= '0;
      end else if (pending_q) begin
        wait_cnt_q <= wait_cnt_q + 1'b1;
      end
    end
  end
  a_read_data: assert property (cmd == CMD_READ |=> cmd_rvalid)
    else $error("no read strobe");
  a_rvalid_cause: assert property (cmd_rvalid |-> $past(cmd) == CMD_READ)
    else $error("stray read strobe");
  a_write_quiet: assert property (cmd == CMD_WRITE |=> !cmd_rvalid)
    else $error("write gave read strobe");
  a_irq_holds: assert property (
    capture_done_interrupt && cmd != CMD_ACK |=> capture_done_interrupt)
    else $error("irq dropped without ack");
  a_ack_clears: assert property (
    cmd == CMD_ACK && parked |-> ##[1:2] !capture_done_interrupt)
    else $error("ack ignored");
  a_capture_bound: assert property (pending_q |-> wait_cnt_q < CAPTURE_LIMIT)
    else $error("capture neither done nor failed");
  a_fail_holds: assert property (!capture_req [*4] ##0 capture_fail |=> capture_fail)
    else $error("fail flag dropped");
  a_fail_unparked: assert property (capture_fail |-> !parked)
    else $error("fail while parked");
  c_read: cover property (cmd == CMD_READ ##1 cmd_rvalid);
  c_park: cover property ($rose(parked));
  c_fail: cover property ($rose(capture_fail));
endmodule

//--- bench/emulation_capture_sequencer_tb.sv
`timescale 1ns/1ps
module emulation_capture_sequencer_tb;
  import capture_pkg::*;
  logic clk = 0, rst_n = 0, cap = 0, stp = 0, nmi = 1;
  logic wr = 0, rd = 0, ack = 0, run = 0, cf = 0, cr = 0, cw = 0, nack = 0, brk = 0;
  logic rvalid, done, fail, crd_en, cnmi, mapped;
  logic [CTL_W-1:0] en = 4'h6, tctl = 4'hA, cctl;
  logic [SCR_AW-1:0] addr = 6'h00;
  logic [DATA_W-1:0] wd = 8'h00, rdata, crd;
  logic [ADDR_W-1:0] ca = 16'h0000, cst = 16'h1234, saved;
  int mismatches = 0, compares = 0;
  always #5 clk = ~clk;
  capture_if link ();
  host_controller_cpu u_host_controller_cpu (.CLK_I(clk), .RST_N_I(rst_n), .DEV(link),
    .CAPTURE_I(cap), .STEP_I(stp), .USE_NMI_I(nmi), .CTL_ENABLE_I(en), .WR_I(wr),
    .RD_I(rd), .ACK_I(ack), .RUN_I(run), .ADDR_I(addr), .WDATA_I(wd), .RDATA_O(rdata),
    .RVALID_O(rvalid), .DONE_O(done), .FAIL_O(fail));
  personality_controller u_personality_controller (.CLK_I(clk), .RST_N_I(rst_n),
    .HOST(link), .CPU_ADDR_I(ca), .CPU_FETCH_I(cf), .CPU_RD_I(cr), .CPU_WR_I(cw),
    .CPU_WDATA_I(wd), .CPU_NMI_ACK_I(nack), .BREAK_I(brk), .TGT_CTL_I(tctl),
    .CPU_STATE_I(cst), .CPU_RDATA_O(crd), .CPU_RDATA_EN_O(crd_en), .CPU_NMI_O(cnmi),
    .SCR_MAPPED_O(mapped), .CPU_CTL_O(cctl), .SAVED_STATE_O(saved));
  capture_sva u_capture_sva (.CLK_I(clk), .RST_N_I(rst_n), .capture_req(link.capture_req),
    .cmd(link.cmd), .cmd_rvalid(link.cmd_rvalid), .parked(link.parked),
    .capture_done_interrupt(link.capture_done_interrupt), .capture_fail(link.capture_fail));
  // ---------------
  // access helpers
  // ---------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // kinds: 0 write, 1 read, 2 ack, 3 run
  task hp(input int k, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    {run, ack, rd, wr} <= 4'h1 << k;
    @(posedge clk);
    {run, ack, rd, wr} <= 4'h0;
  endtask
  // kinds: 0 fetch, 1 read, 2 nmi ack, 3 write
  task cpu(input int k, input logic [15:0] a, input logic [7:0] d = 8'h00);
    @(posedge clk);
    ca <= a;
    wd <= d;
    {cw, nack, cr, cf} <= 4'h1 << k;
    @(posedge clk);
    {cw, nack, cr, cf} <= 4'h0;
    #1;
  endtask
  // bounded wait; longer than the capture timeout so a failure can land
  task wt(input int s);
    logic [4:0] f;
    for (int i = 0; i < 2200; i++) begin
      @(posedge clk);
      #1;
      f = {!mapped, rvalid, fail, done, cnmi};
      if (f[s] === 1'b1) return;
    end
    mismatches++;
    $display("[FAIL] %0t wait %0d timed out", $time, s);
  endtask
  task grab;
    @(posedge clk);
    cap <= 1;
    repeat (8) @(posedge clk);
    wt(0);
    chk(cctl, 4'h0);
    cpu(2, 0);
    wt(1);
    chk(link.parked, 1'b1);
    chk(mapped, 1'b1);
    @(posedge clk);
    cap <= 0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    grab();
    chk(saved, cst);
    hp(2, 0, 0);
    repeat (4) @(posedge clk);
    #1;
    chk(done, 1'b0);
    hp(0, 6'h05, 8'hA5);
    hp(1, 6'h05, 0);
    wt(3);
    chk(rdata, 8'hA5);
    cpu(1, 16'hFF05);
    chk({crd_en, crd}, {1'b1, 8'hA5});
    // a test program stores a result that the host then reads back
    cpu(3, 16'hFF07, 8'h3C);
    hp(1, 6'h07, 0);
    wt(3);
    chk(rdata, 8'h3C);
    cpu(0, 16'hFF3E);
    wt(1);
    chk(done, 1'b1);
    hp(2, 0, 0);
    hp(3, 0, 0);
    hp(1, 6'h3F, 0);
    wt(3);
    chk(rdata, OP_JR);
    cpu(0, 16'hFF3F);
    cpu(0, 16'h0100);
    wt(4);
    chk(cctl, tctl & en);
    // breakpoint with a target that never answers: capture must time out
    @(posedge clk);
    brk <= 1;
    repeat (3) @(posedge clk);
    brk <= 0;
    #1;
    chk(cnmi, 1'b1);
    wt(2);
    chk(fail, 1'b1);
    grab();
    hp(2, 0, 0);
    stp <= 1;
    hp(3, 0, 0);
    cpu(0, 16'hFF3F);
    cpu(0, 16'h0100);
    cpu(0, 16'h0101);
    cpu(0, 16'h0102);
    chk({crd_en, crd}, {1'b1, OP_FORCED});
    wt(1);
    chk(link.parked, 1'b1);
    // capture by forced instruction instead of nmi
    hp(2, 0, 0);
    stp <= 0;
    hp(3, 0, 0);
    cpu(0, 16'hFF3F);
    cpu(0, 16'h0200);
    @(posedge clk);
    nmi <= 0;
    cap <= 1;
    repeat (3) @(posedge clk);
    cpu(0, 16'h0201);
    chk({crd_en, crd, cnmi}, {1'b1, OP_FORCED, 1'b0});
    wt(1);
    chk(link.parked, 1'b1);
    complete_run();
  end
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule
